/* File: logic/cfp_pkg.sv */
// Package: register map, field positions, reset values and timing for the fault/throttle block
package cfp_pkg;
    // ********************************************************************
    // Register offsets
    // ********************************************************************
    localparam logic [7:0] FAULT_FLAGS_OFF = 8'h20;
    localparam logic [7:0] THR_LO_OFF = 8'h22;
    localparam logic [7:0] THR_HI_OFF = 8'h23;

    // ********************************************************************
    // Field positions, fault_flags byte
    // ********************************************************************
    localparam int FF_IN_OV = 7;
    localparam int FF_BAT_OC = 6;
    localparam int FF_IN_OC = 5;
    localparam int FF_SYS_OV = 4;
    localparam int FF_SYS_UV = 3;
    localparam int FF_CONV_OFF = 2;
    localparam int FF_OUT_OV = 1;
    localparam int FF_OUT_UV = 0;

    // ********************************************************************
    // Field positions, throttle_status_control high byte, plus the low-byte regulation bit
    // ********************************************************************
    localparam int TH_EXT_EN = 6;
    localparam int TH_WIDTH_LSB = 4;
    localparam int TH_CLEAR = 3;
    localparam int TH_ASSIST_FAIL = 1;
    localparam int TH_ASSIST_EXIT = 0;
    localparam int TL_VREG = 7;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [7:0] FAULT_FLAGS_RST = 8'h00;
    localparam logic [15:0] THR_RST = 16'hb800;
    localparam logic [1:0] WIDTH_RST = 2'h3;

    // ********************************************************************
    // Timing: clock and pulse widths, plus the restart try limit
    // ********************************************************************
    localparam int CLK_NS = 40;
    localparam int W100US_NS = 100000;
    localparam int W1MS_NS = 1000000;
    localparam int W5MS_NS = 5000000;
    localparam int W10MS_NS = 10000000;
    localparam int W100US_CYC = (W100US_NS + CLK_NS - 1) / CLK_NS;
    localparam int W1MS_CYC = (W1MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int W5MS_CYC = (W5MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int W10MS_CYC = (W10MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESTART_TRIES = 7;

    // Host register access strobe group
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfp_acc_t;

    // Detector event group, one-cycle pulses except the sys_ov_active level
    typedef struct packed {
        logic in_ov;
        logic in_oc;
        logic bat_oc;
        logic bat_ov;
        logic sys_ov;
        logic sys_ov_active;
        logic sys_uv_try_fail;
        logic out_ov;
        logic out_uv;
        logic assist_load_fail;
        logic assist_host_exit;
    } cfp_evt_t;
endpackage

/* File: logic/cfp_pulse_timer.sv */
// Minimum-width pulse timer for the processor-hot output
`timescale 1ns/1ps
`default_nettype none
module cfp_pulse_timer #(
    parameter int W100US = cfp_pkg::W100US_CYC,
    parameter int W1MS = cfp_pkg::W1MS_CYC,
    parameter int W5MS = cfp_pkg::W5MS_CYC,
    parameter int W10MS = cfp_pkg::W10MS_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic start_in,
    input wire logic [1:0] width_in,
    // Status
    output logic busy_out
);
    logic [23:0] cnt_q;

    // Cycle count per width code
    function automatic logic [23:0] width_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: width_cycles = 24'(W100US);
            2'h1: width_cycles = 24'(W1MS);
            2'h2: width_cycles = 24'(W5MS);
            2'h3: width_cycles = 24'(W10MS);
        endcase
    endfunction

    // Load on a trigger, retrigger extends, then count down
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 24'h000000;
        end else if (start_in) begin
            cnt_q <= width_cycles(width_in);
        end else if (cnt_q != 24'h000000) begin
            cnt_q <= cnt_q - 24'h000001;
        end
    end

    assign busy_out = (cnt_q != 24'h000000);
endmodule
`default_nettype wire

/* File: logic/cfp_status_top.sv */
// Fault flags and processor-hot status/control registers of the charge controller
`timescale 1ns/1ps
`default_nettype none
module cfp_status_top #(
    parameter int W100US = cfp_pkg::W100US_CYC,
    parameter int W1MS = cfp_pkg::W1MS_CYC,
    parameter int W5MS = cfp_pkg::W5MS_CYC,
    parameter int W10MS = cfp_pkg::W10MS_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Host register access, already decoded from the serial bus
    input wire cfp_pkg::cfp_acc_t acc_in,
    output logic [7:0] rdata_out,
    // Detector events and levels
    input wire cfp_pkg::cfp_evt_t evt_in,
    input wire logic force_converter_off_ctrl_in,
    input wire logic pass_through_mode_in,
    input wire logic batt_overcurrent_enable_in,
    input wire logic adapter_present_in,
    input wire logic voltage_assist_mode_in,
    input wire logic input_volt_reg_profile_en_in,
    input wire logic [6:0] profile_evt_in,
    // Status outputs
    output logic converter_enable_out,
    output logic assist_allowed_out,
    output logic processor_hot_output_n_out
);
    // ********************************************************************
    // State
    // ********************************************************************
    logic [7:0] fault_q;
    logic [7:0] thr_lo_q;
    logic ext_en_q;
    logic [1:0] width_q;
    logic clear_bit_q;
    logic assist_fail_q;
    logic assist_exit_q;
    logic ext_pulse_q;
    logic [2:0] uv_tries_q;
    logic [2:0] assist_tries_q;
    logic [7:0] rdata_q;
    logic rd_ff, rd_lo, wr_ff, wr_hi, wr_lo;
    logic timer_busy;
    logic hot_req;
    logic bat_oc_set;
    logic uv_set;
    logic assist_fail_set;
    logic assist_exit_set;
    logic vreg_set;

    // Access decode
    assign rd_ff = acc_in.rd && (acc_in.addr == cfp_pkg::FAULT_FLAGS_OFF);
    assign rd_lo = acc_in.rd && (acc_in.addr == cfp_pkg::THR_LO_OFF);
    assign wr_ff = acc_in.wr && (acc_in.addr == cfp_pkg::FAULT_FLAGS_OFF);
    assign wr_lo = acc_in.wr && (acc_in.addr == cfp_pkg::THR_LO_OFF);
    assign wr_hi = acc_in.wr && (acc_in.addr == cfp_pkg::THR_HI_OFF);

    // ********************************************************************
    // Event qualification
    // ********************************************************************
    // Pass-through widens the battery flag to overvoltage; there, enable off makes it inert
    assign bat_oc_set = pass_through_mode_in ?
        (batt_overcurrent_enable_in && (evt_in.bat_oc || evt_in.bat_ov)) :
        evt_in.bat_oc;
    assign uv_set = evt_in.sys_uv_try_fail &&
        (uv_tries_q == 3'(cfp_pkg::RESTART_TRIES - 1));
    assign assist_fail_set = voltage_assist_mode_in && evt_in.assist_load_fail &&
        (assist_tries_q == 3'(cfp_pkg::RESTART_TRIES - 1));
    // Any of these ends assist mode, so they all mark an exit
    assign assist_exit_set = voltage_assist_mode_in && (evt_in.assist_host_exit ||
        evt_in.in_ov || evt_in.in_oc || evt_in.sys_ov || evt_in.bat_ov ||
        uv_set || assist_fail_set);

    // Restart-attempt counter for undervoltage; it clears only when the seventh failure sets the flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            uv_tries_q <= 3'h0;
        end else if (uv_set) begin
            uv_tries_q <= 3'h0;
        end else if (evt_in.sys_uv_try_fail) begin
            uv_tries_q <= uv_tries_q + 3'h1;
        end
    end

    // Consecutive load-failure counter, restarts when assist mode is left
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            assist_tries_q <= 3'h0;
        end else if (!voltage_assist_mode_in || assist_fail_set) begin
            assist_tries_q <= 3'h0;
        end else if (evt_in.assist_load_fail) begin
            assist_tries_q <= assist_tries_q + 3'h1;
        end
    end

    // ********************************************************************
    // Fault flags byte
    // ********************************************************************
    // Read-clear bits: a set in the clearing cycle wins so no event is lost
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fault_q <= cfp_pkg::FAULT_FLAGS_RST;
        end else begin
            fault_q[cfp_pkg::FF_IN_OV] <= evt_in.in_ov ||
                (fault_q[cfp_pkg::FF_IN_OV] && !rd_ff);
            fault_q[cfp_pkg::FF_IN_OC] <= evt_in.in_oc ||
                (fault_q[cfp_pkg::FF_IN_OC] && !rd_ff);
            fault_q[cfp_pkg::FF_OUT_OV] <= evt_in.out_ov ||
                (fault_q[cfp_pkg::FF_OUT_OV] && !rd_ff);
            fault_q[cfp_pkg::FF_OUT_UV] <= evt_in.out_uv ||
                (fault_q[cfp_pkg::FF_OUT_UV] && !rd_ff);
            fault_q[cfp_pkg::FF_CONV_OFF] <= force_converter_off_ctrl_in ||
                (fault_q[cfp_pkg::FF_CONV_OFF] && !rd_ff);
            fault_q[cfp_pkg::FF_BAT_OC] <= bat_oc_set ||
                (fault_q[cfp_pkg::FF_BAT_OC] && !rd_ff);
            // Overvoltage holds while present; write 0 or adapter removal clears after
            fault_q[cfp_pkg::FF_SYS_OV] <= evt_in.sys_ov || evt_in.sys_ov_active ||
                (fault_q[cfp_pkg::FF_SYS_OV] && adapter_present_in &&
                 !(wr_ff && !acc_in.wdata[cfp_pkg::FF_SYS_OV]));
            fault_q[cfp_pkg::FF_SYS_UV] <= uv_set ||
                (fault_q[cfp_pkg::FF_SYS_UV] &&
                 !(wr_ff && !acc_in.wdata[cfp_pkg::FF_SYS_UV]));
        end
    end

    // Converter stays off while overvoltage flag is latched
    assign converter_enable_out = !fault_q[cfp_pkg::FF_SYS_OV];

    // ********************************************************************
    // Throttle status/control, high byte
    // ********************************************************************
    // Host control fields
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_en_q <= cfp_pkg::THR_RST[8 + cfp_pkg::TH_EXT_EN];
            width_q <= cfp_pkg::WIDTH_RST;
            clear_bit_q <= cfp_pkg::THR_RST[8 + cfp_pkg::TH_CLEAR];
        end else if (wr_hi) begin
            ext_en_q <= acc_in.wdata[cfp_pkg::TH_EXT_EN];
            width_q <= acc_in.wdata[cfp_pkg::TH_WIDTH_LSB +: 2];
            clear_bit_q <= acc_in.wdata[cfp_pkg::TH_CLEAR];
        end else begin
            clear_bit_q <= 1'b1; // A written 0 acts once, then the bit returns idle
        end
    end

    // Assist failure and exit flags; write 0 clears, set wins
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            assist_fail_q <= 1'b0;
            assist_exit_q <= 1'b0;
        end else begin
            assist_fail_q <= assist_fail_set || (assist_fail_q &&
                !(wr_hi && !acc_in.wdata[cfp_pkg::TH_ASSIST_FAIL]));
            assist_exit_q <= assist_exit_set || (assist_exit_q &&
                !(wr_hi && !acc_in.wdata[cfp_pkg::TH_ASSIST_EXIT]));
        end
    end

    // Assist mode is locked out while the failure flag stands
    assign assist_allowed_out = !assist_fail_q;

    // ********************************************************************
    // Throttle status, low byte
    // ********************************************************************
    // Profile bits clear on read of this byte; regulation bit clears on write 0
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            thr_lo_q <= cfp_pkg::THR_RST[7:0];
        end else begin
            thr_lo_q[6:0] <= profile_evt_in | (thr_lo_q[6:0] & {7{!rd_lo}});
            thr_lo_q[cfp_pkg::TL_VREG] <= vreg_set ||
                (thr_lo_q[cfp_pkg::TL_VREG] &&
                 !(wr_lo && !acc_in.wdata[cfp_pkg::TL_VREG]));
        end
    end

    // Regulation profile trigger: only counts while the profile is enabled
    assign vreg_set = input_volt_reg_profile_en_in && profile_evt_in[6];

    // ********************************************************************
    // Processor-hot pulse generation
    // ********************************************************************
    // Any new throttle cause starts or retriggers the pulse
    assign hot_req = (|profile_evt_in) || assist_exit_set;

    cfp_pulse_timer #(
        .W100US(W100US),
        .W1MS(W1MS),
        .W5MS(W5MS),
        .W10MS(W10MS)
    ) u_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .start_in(hot_req && !ext_en_q),
        .width_in(width_q),
        .busy_out(timer_busy)
    );

    // Extended pulse holds until pulse-clear is written 0 or extension is turned off; trigger wins over clear
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_pulse_q <= 1'b0;
        end else if (hot_req && ext_en_q) begin
            ext_pulse_q <= 1'b1;
        end else if (!clear_bit_q || !ext_en_q) begin
            ext_pulse_q <= 1'b0;
        end
    end

    // Output low while any holder requests it
    assign processor_hot_output_n_out = !(timer_busy || ext_pulse_q || assist_exit_q ||
        (input_volt_reg_profile_en_in && thr_lo_q[cfp_pkg::TL_VREG]));

    // ********************************************************************
    // Read data
    // ********************************************************************
    // Registered read data, unmapped offsets read zero
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= 8'h00;
        end else if (acc_in.rd) begin
            unique case (acc_in.addr)
                cfp_pkg::FAULT_FLAGS_OFF: rdata_q <= fault_q;
                cfp_pkg::THR_LO_OFF: rdata_q <= thr_lo_q;
                cfp_pkg::THR_HI_OFF: rdata_q <= {1'b1, ext_en_q, width_q, clear_bit_q,
                    1'b0, assist_fail_q, assist_exit_q};
                default: rdata_q <= 8'h00;
            endcase
        end
    end
    assign rdata_out = rdata_q;

    // ********************************************************************
    // Checks
    // ********************************************************************
    AST_READ_CLEARS_INOV: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_ff && !evt_in.in_ov |=> !fault_q[cfp_pkg::FF_IN_OV])
        else $error("input overvoltage flag not cleared by read");
    AST_READ_CLEARS_INOC: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_ff && !evt_in.in_oc |=> !fault_q[cfp_pkg::FF_IN_OC])
        else $error("input overcurrent flag not cleared by read");
    AST_OUT_OV_LATCH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        evt_in.out_ov |=> fault_q[cfp_pkg::FF_OUT_OV])
        else $error("output overvoltage not latched");
    AST_BATTERY_OVERCURRENT_INERT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        pass_through_mode_in && !batt_overcurrent_enable_in && rd_ff
        |=> !fault_q[cfp_pkg::FF_BAT_OC])
        else $error("battery flag set with enable off in pass-through");
    AST_PTM_BATOV: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        pass_through_mode_in && batt_overcurrent_enable_in && evt_in.bat_ov
        |=> fault_q[cfp_pkg::FF_BAT_OC])
        else $error("battery overvoltage not flagged in pass-through");
    AST_BATTERY_OVERCURRENT_NORMAL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !pass_through_mode_in && evt_in.bat_oc |=> fault_q[cfp_pkg::FF_BAT_OC])
        else $error("battery overcurrent not latched");
    AST_SYSOV_CONV_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        evt_in.sys_ov |=> !converter_enable_out)
        else $error("converter enabled during system overvoltage");
    AST_SYSOV_ACTIVE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        evt_in.sys_ov_active |=> fault_q[cfp_pkg::FF_SYS_OV] && !converter_enable_out)
        else $error("converter enabled while overvoltage present");
    AST_SYSOV_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        fault_q[cfp_pkg::FF_SYS_OV] && adapter_present_in && !wr_ff
        |=> fault_q[cfp_pkg::FF_SYS_OV])
        else $error("overvoltage latch dropped without host clear");
    AST_SYSOV_WR_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_ff && !acc_in.wdata[cfp_pkg::FF_SYS_OV] && !evt_in.sys_ov && !evt_in.sys_ov_active
        |=> converter_enable_out)
        else $error("converter not re-enabled by host clear");
    AST_ADAPTER_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !adapter_present_in && !evt_in.sys_ov && !evt_in.sys_ov_active
        |=> converter_enable_out)
        else $error("converter not re-enabled on adapter removal");
    AST_UV_ONLY_SEVENTH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(fault_q[cfp_pkg::FF_SYS_UV]) |-> $past(uv_tries_q) == 3'h6)
        else $error("undervoltage flag set before seventh failed try");
    AST_UV_STICKY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        fault_q[cfp_pkg::FF_SYS_UV] && !wr_ff |=> fault_q[cfp_pkg::FF_SYS_UV])
        else $error("undervoltage flag cleared without write");
    AST_UV_WR_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_ff && !acc_in.wdata[cfp_pkg::FF_SYS_UV] && !uv_set
        |=> !fault_q[cfp_pkg::FF_SYS_UV])
        else $error("undervoltage flag not cleared by write");
    AST_CONV_OFF_FLAG: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        force_converter_off_ctrl_in |=> fault_q[cfp_pkg::FF_CONV_OFF])
        else $error("forced-off flag not set");
    AST_PROFILE_READ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_lo && profile_evt_in == 7'h00 |=> thr_lo_q[6:0] == 7'h00)
        else $error("profile bits not cleared by read");
    AST_PROFILE_LATCH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        |profile_evt_in |=> (thr_lo_q[6:0] & $past(profile_evt_in)) == $past(profile_evt_in))
        else $error("profile trigger not latched");
    AST_EXT_START: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        hot_req && ext_en_q |=> ext_pulse_q && !processor_hot_output_n_out)
        else $error("extended pulse not started");
    AST_EXT_HOLDS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ext_pulse_q && ext_en_q && clear_bit_q |=> !processor_hot_output_n_out)
        else $error("extended pulse released early");
    AST_MIN_WIDTH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        hot_req && !ext_en_q |=> !processor_hot_output_n_out [*8])
        else $error("throttle pulse shorter than minimum");
    AST_CLEAR_ENDS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !clear_bit_q && !hot_req |=> !ext_pulse_q)
        else $error("pulse clear did not end extended pulse");
    AST_CLEAR_IDLE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !wr_hi |=> clear_bit_q)
        else $error("pulse clear bit not back to idle");
    AST_ASSIST_SEVENTH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(assist_fail_q) |-> $past(assist_tries_q) == 3'h6)
        else $error("assist failure flagged before seventh failure");
    AST_FAIL_LOCK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        assist_fail_set |=> !assist_allowed_out && assist_exit_q)
        else $error("assist failure did not lock out");
    AST_FAIL_STICKY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        assist_fail_q && !wr_hi |=> assist_fail_q)
        else $error("assist failure flag cleared without write");
    AST_EXIT_LOW: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        assist_exit_q |-> !processor_hot_output_n_out)
        else $error("output high while exit flag set");
    AST_EXIT_STICKY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        assist_exit_q && !wr_hi |=> assist_exit_q)
        else $error("assist exit flag cleared without write");
    AST_VREG_STICKY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        thr_lo_q[cfp_pkg::TL_VREG] && !wr_lo |=> thr_lo_q[cfp_pkg::TL_VREG])
        else $error("regulation status cleared without write");
endmodule
`default_nettype wire

/* File: dv/cfp_host_model.sv */
// Host-side register access model that drives the decoded access strobes
`timescale 1ns/1ps
`default_nettype none
module cfp_host_model (
    // Clock
    input wire logic clk_in,
    // Register access
    output var cfp_pkg::cfp_acc_t acc_out,
    input wire logic [7:0] rdata_in
);
    // ********************************************************************
    // Access transfer
    // ********************************************************************
    // Bus idles with no strobe until the first request
    initial acc_out = '0;

    // One request per call; the trailing idle cycle keeps a strobe from being set twice at once
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        acc_out = '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk_in);
        #1;
        q = rdata_in;
        acc_out = '0;
        @(posedge clk_in);
        #1;
    endtask
endmodule
`default_nettype wire

/* File: dv/cfp_status_top_tb.sv */
// Self-checking bench for the fault flags and processor-hot status block
`timescale 1ns/1ps
`default_nettype none
module cfp_status_top_tb;
    // ********************************************************************
    // Stimulus, checks and test sequence
    // ********************************************************************
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    cfp_pkg::cfp_acc_t acc;
    cfp_pkg::cfp_evt_t evt = '0;
    logic fco = 1'b0, pass_through_mode = 1'b0, boe = 1'b0, adp = 1'b1, vam = 1'b0, ppe = 1'b0;
    logic [6:0] pev = '0;
    logic [7:0] rdata, q;
    logic [3:0] c;
    logic conv_en, asst_ok, hot_n;
    int err_count = 0;
    int cmp_count = 0;
    int n;

    // Free-running 25 MHz clock
    always #20 clk_in = ~clk_in;

    cfp_host_model u_host (.clk_in(clk_in), .acc_out(acc), .rdata_in(rdata));

    // Short widths keep the run brief: 8, 12, 16, 20 cycles for codes 0..3
    // The shortest must still cover the 8-cycle window of the minimum-width check
    cfp_status_top #(.W100US(8), .W1MS(12), .W5MS(16), .W10MS(20)) u_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .acc_in(acc), .rdata_out(rdata),
        .evt_in(evt), .force_converter_off_ctrl_in(fco), .pass_through_mode_in(pass_through_mode),
        .batt_overcurrent_enable_in(boe), .adapter_present_in(adp),
        .voltage_assist_mode_in(vam), .input_volt_reg_profile_en_in(ppe),
        .profile_evt_in(pev), .converter_enable_out(conv_en),
        .assist_allowed_out(asst_ok), .processor_hot_output_n_out(hot_n));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        u_host.xfer(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(1'b1, a, d, q);
    endtask
    task automatic bit1(input logic s, input logic e);
        chk({7'h00, s}, {7'h00, e});
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    // Detector pulses last one cycle, followed by a quiet cycle
    task automatic pulse(input cfp_pkg::cfp_evt_t e, input logic [6:0] p);
        evt = e;
        pev = p;
        idle(1);
        evt = '0;
        pev = '0;
        idle(1);
    endtask
    task automatic close_out();
        $display("compares=%0d errors=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        close_out();
    end

    // Main sequence
    initial begin
        idle(3);
        rst_n_in = 1'b1;
        bit1(hot_n, 1'b1);
        rd(8'h20, 8'h00);
        rd(8'h23, 8'hb8);
        rd(8'h22, 8'h00);
        wr(8'h21, 8'hff);
        rd(8'h21, 8'h00);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00);
        pulse(11'h60c, 7'h00);
        rd(8'h20, 8'ha3);
        rd(8'h20, 8'h00);
        fco = 1'b1;
        idle(2);
        fco = 1'b0;
        idle(1);
        rd(8'h20, 8'h04);
        rd(8'h20, 8'h00);
        // Nibble per case: pass-through, enable, use OV event, expected flag
        for (int i = 0; i < 4; i++) begin
            c = 4'(16'h21f8 >> (4 * i));
            pass_through_mode = c[3];
            boe = c[2];
            pulse(c[1] ? 11'h080 : 11'h100, 7'h00);
            rd(8'h20, {1'b0, c[0], 6'h00});
        end
        pass_through_mode = 1'b0;
        boe = 1'b0;
        evt = 11'h060;
        idle(1);
        evt = 11'h020;
        idle(1);
        bit1(conv_en, 1'b0);
        evt = '0;
        idle(2);
        bit1(conv_en, 1'b0);
        rd(8'h20, 8'h10);
        wr(8'h20, 8'h00);
        bit1(conv_en, 1'b1);
        rd(8'h20, 8'h00);
        evt = 11'h060;
        idle(1);
        evt = '0;
        adp = 1'b0;
        idle(2);
        bit1(conv_en, 1'b1);
        rd(8'h20, 8'h00);
        adp = 1'b1;
        for (int i = 0; i < 7; i++) begin
            if (i == 6) rd(8'h20, 8'h00);
            pulse(11'h010, 7'h00);
        end
        rd(8'h20, 8'h08);
        rd(8'h20, 8'h08);
        wr(8'h20, 8'h00);
        rd(8'h20, 8'h00);
        ppe = 1'b1;
        pulse(11'h000, 7'h7f);
        rd(8'h22, 8'hff);
        rd(8'h22, 8'h80);
        idle(30);
        bit1(hot_n, 1'b0);
        wr(8'h22, 8'h00);
        bit1(hot_n, 1'b1);
        ppe = 1'b0;
        // Each width code: the pulse must stay low at least 4*(code+2) cycles
        for (int w = 0; w < 4; w++) begin
            wr(8'h23, 8'h08 | 8'(w << 4));
            rd(8'h23, 8'h88 | 8'(w << 4));
            pulse(11'h000, 7'h01);
            n = 1;
            while (hot_n === 1'b0 && n < 100) begin
                idle(1);
                n++;
            end
            bit1(n >= 4 * (w + 2), 1'b1);
            bit1(hot_n, 1'b1);
        end
        wr(8'h23, 8'h78);
        pulse(11'h000, 7'h01);
        idle(30);
        bit1(hot_n, 1'b0);
        rd(8'h23, 8'hf8);
        wr(8'h23, 8'h70);
        bit1(hot_n, 1'b1);
        rd(8'h23, 8'hf8);
        wr(8'h23, 8'h38);
        vam = 1'b1;
        for (int i = 0; i < 7; i++) begin
            if (i == 6) rd(8'h23, 8'hb8);
            pulse(11'h002, 7'h00);
        end
        rd(8'h23, 8'hbb);
        bit1(asst_ok, 1'b0);
        idle(30);
        bit1(hot_n, 1'b0);
        wr(8'h23, 8'h38);
        bit1(asst_ok, 1'b1);
        bit1(hot_n, 1'b1);
        // Host-commanded exit, then a fault-driven exit
        for (int i = 0; i < 2; i++) begin
            pulse(i ? 11'h400 : 11'h001, 7'h00);
            idle(30);
            bit1(hot_n, 1'b0);
            rd(8'h23, 8'hb9);
            wr(8'h23, 8'h38);
            bit1(hot_n, 1'b1);
        end
        rd(8'h20, 8'h80);
        vam = 1'b0;
        // Mid-run reset with state set: the fault flags and high byte must return to their power-on values
        wr(8'h23, 8'h40);
        pulse(11'h040, 7'h01);
        bit1(conv_en, 1'b0);
        bit1(hot_n, 1'b0);
        rst_n_in = 1'b0;
        idle(2);
        bit1(hot_n, 1'b1);
        bit1(conv_en, 1'b1);
        rst_n_in = 1'b1;
        rd(8'h20, 8'h00);
        rd(8'h23, 8'hb8);
        close_out();
    end
endmodule
`default_nettype wire
